// ==== hdl/flse_lockbits.sv ====
// Purpose: Store of the per-block lock bits.
// Assumes: Nonvolatility is modelled by reset to the erased value.
// Notes: Bits clear only by lock programming and set only by erase.
`timescale 1ns/100ps
module flse_lockbits
	import flse_pkg::*;
#(
	parameter int N = NUM_BLOCKS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [$clog2(N)-1:0] sel,
	input wire logic clr_sel,
	input wire logic set_sel,
	output logic [N-1:0] bits
);
	initial begin
		if (N < 2) $error("flse_lockbits: N too small");
	end
	// Per-bit update; set comes only from a finished erase.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bits <= {N{LOCK_RESET}};
		end else if (set_sel) begin
			bits[sel] <= 1'b1;
		end else if (clr_sel) begin
			bits[sel] <= 1'b0;
		end
	end
endmodule : flse_lockbits

// ==== hdl/flse_pkg.sv ====
// Purpose: Shared constants for the flash lock, erase and status sequencer.
// Assumes: Command codes are compared on the low byte only.
// Notes: Timing counts are cycles of the 40 MHz system clock.
package flse_pkg;
	// Command codes, low byte of the written word.
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
	localparam logic [7:0] CMD_ERASE_ALL = 8'ha7;
	localparam logic [7:0] CMD_LOCK_PROGRAM = 8'h77;
	localparam logic [7:0] CMD_LOCK_READ = 8'h71;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	// Status byte bit positions.
	localparam int STAT_READY_POS = 7;
	localparam int STAT_ERASE_POS = 5;
	localparam int STAT_PROG_POS = 4;
	// Block map: blocks 0..8 plus the small block at index 9.
	localparam int NUM_BLOCKS = 10;
	localparam int LAST_BULK_BLOCK = 8;
	localparam int SMALL_BLOCK = 9;
	// Reset value of every lock bit (erased, unlocked).
	localparam logic LOCK_RESET = 1'b1;
	// Operation times in cycles of the array model.
	localparam int ERASE_CYCLES = 16;
	localparam int PROG_CYCLES = 4;
	localparam int LOCK_CYCLES = 4;
	// Sequencer states.
	typedef enum logic [2:0] {FLSE_IDLE, FLSE_WAIT2, FLSE_BUSY_PROG, FLSE_BUSY_ERASE,
		FLSE_BUSY_BULK, FLSE_BUSY_LOCK, FLSE_BUSY_LREAD} flse_state_t;
endpackage : flse_pkg

// ==== hdl/flse_sequencer.sv ====
// Function
// - A7h then D0h starts bulk erase
// - Bulk erase covers blocks zero to eight
// - Ready low while any operation runs
// - RAM mode shows status once erase starts
// - 77h then D0h clears block lock
// - 71h then D0h loads lock result
// - Zero lock bit blocks program and erase
// - Lock set only by erase
// - Disable flag unlocks all, bits retained
// - Disabled erase sets erased lock bits
// - Status byte D7 ready, D5, D4 errors
// - RAM mode reads status after operations
// - Clear resets errors; errors reject program, erase and lock program
// - Error pair encodes cause
// - Bad second cycle flags sequence error
// - FFh second cycle cancels to read, except after 40h
// - Erase error on locked or failed erase
// - Program error on locked or failed program
// - Disabled protection suppresses lock errors
// - Commands use low byte only
// - FFh enters array read mode
// - 50h clears both error flags
// - 70h makes next read status
//
// Purpose: Command decoder and sequencer for flash rewrite with lock protection.
// Assumes: One write or read strobe per cycle; addresses are already even and in user area.
// Notes: The array itself is outside; its verify result arrives on the verify_fail input.
`timescale 1ns/100ps
module flse_sequencer
	import flse_pkg::*;
#(
	parameter int N_BLK = NUM_BLOCKS,
	parameter int TW = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cmd_wr,
	input wire logic [15:0] cmd_data,
	input wire logic [$clog2(N_BLK)-1:0] cmd_block,
	input wire logic cmd_top_addr,
	input wire logic rd_en,
	input wire logic [15:0] array_rdata,
	input wire logic ram_exec_rewrite_mode,
	input wire logic lock_protect_disable,
	input wire logic verify_fail,
	output logic [15:0] rd_data,
	output logic status_mode,
	output logic sequencer_ready_flag,
	output logic erase_error_flag,
	output logic program_error_flag,
	output logic lock_state_result,
	output logic [7:0] flash_status_readback,
	output logic array_prog_go,
	output logic array_erase_go,
	output logic [$clog2(N_BLK)-1:0] array_block
);
	localparam int BW = $clog2(N_BLK);

	initial begin
		if (N_BLK != NUM_BLOCKS) $error("flse_sequencer: block map is fixed");
		if (TW < 5) $error("flse_sequencer: timer too narrow");
	end

	////////////////////////////////////////////////////////////////////////////////
	// State.

	flse_state_t state_r, state_nxt; // Sequencer state.
	logic [7:0] first_r; // First-cycle command code.
	logic [BW-1:0] first_blk_r; // Block given in the first cycle.
	logic [BW-1:0] blk_r; // Block under operation.
	logic status_mode_r; // Reads return the status byte.
	logic status_once_r; // One status read pending after 70h.
	logic eerr_r; // Erase error flag.
	logic perr_r; // Program error flag.
	logic lres_r; // Lock state result.
	logic fail_seen_r; // Any verify fail during a bulk erase.
	logic [BW-1:0] blk_nxt;
	logic timer_start;
	logic [TW-1:0] timer_load;
	logic timer_done;
	logic [N_BLK-1:0] lock_bits;
	logic lock_clr, lock_set;

	////////////////////////////////////////////////////////////////////////////////
	// Decode of the incoming command word.

	wire [7:0] code = cmd_data[7:0];
	wire is_idle = (state_r == FLSE_IDLE);
	wire is_wait2 = (state_r == FLSE_WAIT2);
	wire err_any = eerr_r | perr_r;
	wire wr1 = cmd_wr && is_idle;
	wire wr2 = cmd_wr && is_wait2;
	// Two-cycle first codes.
	wire two_cycle = (code == CMD_PROGRAM) || (code == CMD_BLOCK_ERASE) || (code == CMD_ERASE_ALL) ||
		(code == CMD_LOCK_PROGRAM) || (code == CMD_LOCK_READ);
	// Commands refused while an error flag stands; lock read stays allowed.
	wire guarded = (code == CMD_PROGRAM) || (code == CMD_BLOCK_ERASE) || (code == CMD_ERASE_ALL) ||
		(code == CMD_LOCK_PROGRAM);
	wire known1 = two_cycle || (code == CMD_READ_ARRAY) || (code == CMD_READ_STATUS) ||
		(code == CMD_CLEAR_STATUS);
	wire confirm = (code == CMD_CONFIRM);
	wire cancel = (code == CMD_READ_ARRAY) && (first_r != CMD_PROGRAM);
	// Effective lock: protection off makes every block unlocked.
	wire [N_BLK-1:0] unlocked = lock_bits | {N_BLK{lock_protect_disable}};
	wire sel_unlocked = unlocked[cmd_block];
	// Block addressing: lock commands need the top even address; lock program also needs the same block in both cycles.
	wire addr_ok = cmd_top_addr && (cmd_block == first_blk_r);
	// A malformed second cycle: wrong confirm value, or bad lock address.
	wire seq_err2 = wr2 && (first_r != CMD_PROGRAM) && !cancel &&
		(!confirm || (((first_r == CMD_LOCK_PROGRAM) || (first_r == CMD_LOCK_READ)) && !cmd_top_addr) ||
		((first_r == CMD_LOCK_PROGRAM) && !addr_ok));
	wire seq_err1 = wr1 && !known1;
	wire go2 = wr2 && !seq_err2 && !cancel && (first_r == CMD_PROGRAM || confirm);
	// Locked target of program or block erase: error, no array activity.
	wire locked_hit = go2 && !sel_unlocked &&
		((first_r == CMD_PROGRAM) || (first_r == CMD_BLOCK_ERASE));
	// First unlocked block at or after a start point, for the bulk walk.
	function automatic logic [BW:0] next_bulk(input logic [BW-1:0] from, input logic [N_BLK-1:0] ok);
		logic [BW:0] r;
		r = {1'b1, {BW{1'b0}}};
		for (int i = LAST_BULK_BLOCK; i >= 0; i--) begin
			if (i >= int'(from) && ok[i]) r = {1'b0, BW'(i)};
		end
		return r;
	endfunction : next_bulk
	wire [BW:0] bulk_first = next_bulk('0, unlocked);
	wire [BW:0] bulk_after = (int'(blk_r) >= LAST_BULK_BLOCK) ? {1'b1, {BW{1'b0}}} :
		next_bulk(blk_r + BW'(1), unlocked);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Pick the next state and start the array timer.
	always_comb begin
		state_nxt = state_r;
		blk_nxt = blk_r;
		timer_start = 1'b0;
		timer_load = TW'(PROG_CYCLES);
		case (state_r)
			FLSE_IDLE: begin
				if (wr1 && two_cycle && !(guarded && err_any)) begin
					state_nxt = FLSE_WAIT2;
				end
			end
			FLSE_WAIT2: begin
				if (cmd_wr) begin
					state_nxt = FLSE_IDLE;
					blk_nxt = cmd_block;
					if (go2 && !locked_hit) begin
						timer_start = 1'b1;
						case (first_r)
							CMD_PROGRAM: begin
								state_nxt = FLSE_BUSY_PROG;
							end
							CMD_BLOCK_ERASE: begin
								state_nxt = FLSE_BUSY_ERASE;
								timer_load = TW'(ERASE_CYCLES);
							end
							CMD_ERASE_ALL: begin
								timer_load = TW'(ERASE_CYCLES);
								if (bulk_first[BW]) begin
									state_nxt = FLSE_IDLE;
									timer_start = 1'b0;
								end else begin
									state_nxt = FLSE_BUSY_BULK;
									blk_nxt = bulk_first[BW-1:0];
								end
							end
							CMD_LOCK_PROGRAM: begin
								state_nxt = FLSE_BUSY_LOCK;
								timer_load = TW'(LOCK_CYCLES);
							end
							default: begin
								state_nxt = FLSE_BUSY_LREAD;
								timer_load = TW'(LOCK_CYCLES);
							end
						endcase
					end
				end
			end
			FLSE_BUSY_BULK: begin
				if (timer_done) begin
					if (bulk_after[BW]) begin
						state_nxt = FLSE_IDLE;
					end else begin
						blk_nxt = bulk_after[BW-1:0];
						timer_start = 1'b1;
						timer_load = TW'(ERASE_CYCLES);
					end
				end
			end
			FLSE_BUSY_PROG, FLSE_BUSY_ERASE, FLSE_BUSY_LOCK, FLSE_BUSY_LREAD: begin
				if (timer_done) state_nxt = FLSE_IDLE;
			end
			default: begin
				state_nxt = FLSE_IDLE;
			end
		endcase
	end

	// Finishing events; bulk erase ends a block on each timer pulse.
	wire end_erase = timer_done && ((state_r == FLSE_BUSY_ERASE) || (state_r == FLSE_BUSY_BULK));
	wire end_prog = timer_done && (state_r == FLSE_BUSY_PROG);
	wire end_lock = timer_done && (state_r == FLSE_BUSY_LOCK);
	assign lock_set = end_erase && !verify_fail;
	assign lock_clr = end_lock && !verify_fail;

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	// State, command capture and operated block.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= FLSE_IDLE;
			first_r <= 8'h00;
			first_blk_r <= '0;
			blk_r <= '0;
		end else begin
			state_r <= state_nxt;
			blk_r <= blk_nxt;
			if (wr1) begin
				first_r <= code;
				first_blk_r <= cmd_block;
			end
		end
	end

	// Error flags; a new error wins over a clear in the same cycle.
	wire clr_cmd = wr1 && (code == CMD_CLEAR_STATUS);
	wire set_e = seq_err1 || seq_err2 || (locked_hit && first_r == CMD_BLOCK_ERASE) ||
		(end_erase && verify_fail);
	wire set_p = seq_err1 || seq_err2 || (locked_hit && first_r == CMD_PROGRAM) ||
		((end_prog || end_lock) && verify_fail);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			eerr_r <= 1'b0;
			perr_r <= 1'b0;
			fail_seen_r <= 1'b0;
		end else begin
			eerr_r <= set_e | (eerr_r & ~clr_cmd);
			perr_r <= set_p | (perr_r & ~clr_cmd);
			fail_seen_r <= (state_r == FLSE_BUSY_BULK) & (fail_seen_r | (timer_done & verify_fail));
		end
	end

	// Read mode: status after operations in RAM mode, or once after 70h.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			status_mode_r <= 1'b0;
			status_once_r <= 1'b0;
			lres_r <= 1'b0;
		end else begin
			if (wr1 && code == CMD_READ_ARRAY) begin
				status_mode_r <= 1'b0;
			end else if (wr2 && (cancel || first_r == CMD_LOCK_READ)) begin
				status_mode_r <= 1'b0;
			end else if (timer_start && ram_exec_rewrite_mode && is_wait2) begin
				status_mode_r <= 1'b1;
			end
			if (wr1 && code == CMD_READ_STATUS) begin
				status_once_r <= 1'b1;
			end else if (rd_en || cmd_wr) begin
				status_once_r <= 1'b0;
			end
			if (timer_done && state_r == FLSE_BUSY_LREAD) begin
				lres_r <= lock_bits[blk_r];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Submodules.

	flse_timer #(.W(TW)) u_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(timer_start),
		.load(timer_load),
		.done(timer_done)
	);

	flse_lockbits #(.N(N_BLK)) u_locks (
		.sys_clk(sys_clk),
		.rst(rst),
		.sel(blk_r),
		.clr_sel(lock_clr),
		.set_sel(lock_set),
		.bits(lock_bits)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	wire busy = !is_idle && !is_wait2;
	assign sequencer_ready_flag = !busy;
	assign erase_error_flag = eerr_r;
	assign program_error_flag = perr_r;
	assign lock_state_result = lres_r;
	assign status_mode = status_mode_r || status_once_r;
	// Status byte; reserved bits are zero.
	assign flash_status_readback = {!busy, 1'b0, eerr_r, perr_r, 4'h0};
	assign array_prog_go = timer_start && state_r == FLSE_WAIT2 && first_r == CMD_PROGRAM;
	assign array_erase_go = timer_start && (first_r == CMD_BLOCK_ERASE || first_r == CMD_ERASE_ALL);
	assign array_block = blk_nxt;

	// Registered read data.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_data <= 16'h0000;
		end else if (rd_en) begin
			rd_data <= status_mode ? {8'h00, flash_status_readback} : array_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	// Ready must drop on the edge after a start and stay low until the timer ends the operation.
	a_ready_busy: assert property (@(posedge sys_clk) disable iff (rst)
		timer_start || (busy && !timer_done) |=> !sequencer_ready_flag && !flash_status_readback[STAT_READY_POS])
		else $error("ready high while busy");
	a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
		flash_status_readback[3:0] == 4'h0 && !flash_status_readback[6]) else $error("reserved bit set");
	a_clear_errors: assert property (@(posedge sys_clk) disable iff (rst)
		clr_cmd && !set_e && !set_p |=> !eerr_r && !perr_r) else $error("clear failed");
	a_reject_on_err: assert property (@(posedge sys_clk) disable iff (rst)
		wr1 && guarded && err_any |=> is_idle) else $error("command taken under error");
	a_seq_err_pair: assert property (@(posedge sys_clk) disable iff (rst)
		seq_err2 |=> eerr_r && perr_r) else $error("sequence error not flagged");
	a_cancel_clean: assert property (@(posedge sys_clk) disable iff (rst)
		wr2 && cancel && !err_any |=> is_idle && !eerr_r && !perr_r) else $error("cancel misbehaved");
	a_bulk_range: assert property (@(posedge sys_clk) disable iff (rst)
		state_r == FLSE_BUSY_BULK |-> int'(blk_r) <= LAST_BULK_BLOCK) else $error("bulk erase left range");
	// A failed verify on any block of the walk must leave the erase error standing.
	a_bulk_fail: assert property (@(posedge sys_clk) disable iff (rst)
		fail_seen_r |-> eerr_r) else $error("bulk verify fail lost");
	a_lock_disabled: assert property (@(posedge sys_clk) disable iff (rst)
		lock_protect_disable && go2 && (first_r == CMD_PROGRAM || first_r == CMD_BLOCK_ERASE) |=> busy)
		else $error("lock refused while disabled");
	a_ram_status: assert property (@(posedge sys_clk) disable iff (rst)
		array_erase_go && ram_exec_rewrite_mode && is_wait2 |=> status_mode) else $error("no status mode");
endmodule : flse_sequencer

// ==== hdl/flse_timer.sv ====
// Purpose: Down counter that times one array operation.
// Assumes: start is a one-cycle pulse; a new start reloads the count.
// Notes: done is a one-cycle pulse when the count expires.
`timescale 1ns/100ps
module flse_timer #(
	parameter int W = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [W-1:0] load,
	output logic done
);
	logic [W-1:0] cnt_r; // Remaining cycles.
	logic run_r; // Counter is active.
	initial begin
		if (W < 2) $error("flse_timer: W too small");
	end
	// Count down and pulse on expiry.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_r <= '0;
			run_r <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_r <= load;
				run_r <= 1'b1;
			end else if (run_r) begin
				if (cnt_r <= W'(1)) begin
					run_r <= 1'b0;
					done <= 1'b1;
				end
				cnt_r <= cnt_r - W'(1);
			end
		end
	end
endmodule : flse_timer

// ==== test/flse_array_model.sv ====
// Purpose: Behavioural model of the flash array behind the sequencer.
// Assumes: The bench chooses when a verify fails through fail_mode.
// Notes: Records which blocks saw an erase start so the bench can check coverage.
`timescale 1ns/100ps
module flse_array_model
	import flse_pkg::*;
#(
	parameter logic [15:0] DATA_WORD = 16'h3c5a
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic rd_en,
	input wire logic fail_mode,
	input wire logic clr_erased,
	input wire logic erase_go,
	input wire logic [3:0] blk,
	output logic [15:0] array_rdata,
	output logic verify_fail,
	output logic [NUM_BLOCKS-1:0] erased_r
);
	// Idle pattern; it changes every cycle so a stale word never passes for an answer.
	logic [15:0] noise_r;

	////////////////////////////////////////////////////////////////////////////////
	// The array drives a word only while it is read.
	assign array_rdata = rd_en ? DATA_WORD : noise_r;
	// A failing verify is held as a level, as the sequencer samples it at operation end.
	assign verify_fail = fail_mode;

	// Noise and the erase record; a restart of the record is the bench's choice.
	always_ff @(posedge sys_clk) begin
		noise_r <= rst ? 16'ha5a5 : ~noise_r + 16'h0001;
		if (rst || clr_erased) begin
			erased_r <= '0;
		end else if (erase_go) begin
			erased_r[blk] <= 1'b1;
		end
	end
endmodule : flse_array_model

// ==== test/flse_sequencer_test.sv ====
// Purpose: Self-checking bench for the flash lock, erase and status sequencer.
// Assumes: Only RAM-executed or plain mode is used, never erase-all from flash code.
// Notes: Table rows hold two-cycle commands, lock and erase-all rejects included; working lock and erase-all cases follow by hand.
`timescale 1ns/100ps
module flse_sequencer_test
	import flse_pkg::*;
;
	typedef struct packed {logic [15:0] c1; logic [15:0] c2; logic [3:0] b; logic t; logic f; logic [7:0] st;} flse_row_t;
	logic sys_clk, rst, cmd_wr, cmd_top_addr, rd_en, ram_mode, prot_off, fail_mode, clr_erased;
	logic [15:0] cmd_data, array_rdata, rd_data, v;
	logic [3:0] cmd_block, array_block;
	logic status_mode, rdy, eerr, perr, lock_res, prog_go, erase_go, verify_fail;
	logic [7:0] stat;
	logic [NUM_BLOCKS-1:0] erased;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int prog_cnt = 0; // Program starts seen at the array side.
	// Ordinary two-cycle cases: first word, second word, block, top address, verify fail, status.
	flse_row_t rows [10] = '{
		'{16'h5a20, 16'h00d0, 4'h3, 1'b1, 1'b0, 8'h80}, '{16'h0020, 16'h00d0, 4'h3, 1'b1, 1'b1, 8'ha0},
		'{16'h0040, 16'h1234, 4'h2, 1'b0, 1'b1, 8'h90}, '{16'h0040, 16'h00d0, 4'h2, 1'b0, 1'b0, 8'h80},
		'{16'h0020, 16'h0055, 4'h3, 1'b1, 1'b0, 8'hb0}, '{16'h0077, 16'h0033, 4'h3, 1'b1, 1'b0, 8'hb0},
		'{16'h00a7, 16'h0012, 4'h0, 1'b0, 1'b0, 8'hb0}, '{16'h0020, 16'h00ff, 4'h3, 1'b1, 1'b0, 8'h80},
		'{16'h0077, 16'h00ff, 4'h3, 1'b1, 1'b0, 8'h80}, '{16'h0077, 16'h00d0, 4'h4, 1'b0, 1'b0, 8'hb0}};

	////////////////////////////////////////////////////////////////////////////////
	flse_sequencer DUT (.sys_clk(sys_clk), .rst(rst), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
		.cmd_block(cmd_block), .cmd_top_addr(cmd_top_addr), .rd_en(rd_en), .array_rdata(array_rdata),
		.ram_exec_rewrite_mode(ram_mode), .lock_protect_disable(prot_off), .verify_fail(verify_fail),
		.rd_data(rd_data), .status_mode(status_mode), .sequencer_ready_flag(rdy), .erase_error_flag(eerr),
		.program_error_flag(perr), .lock_state_result(lock_res), .flash_status_readback(stat),
		.array_prog_go(prog_go), .array_erase_go(erase_go), .array_block(array_block));
	flse_array_model u_model (.sys_clk(sys_clk), .rst(rst), .rd_en(rd_en), .fail_mode(fail_mode),
		.clr_erased(clr_erased), .erase_go(erase_go), .blk(array_block), .array_rdata(array_rdata),
		.verify_fail(verify_fail), .erased_r(erased));

	////////////////////////////////////////////////////////////////////////////////
	// Compare tasks, one for each width of result.
	task automatic chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk16
	// One command write; the strobe stands for exactly one edge.
	task automatic wr(input logic [15:0] d, input logic [3:0] b, input logic t);
		@(posedge sys_clk);
		cmd_wr <= 1'b1;
		cmd_data <= d;
		cmd_block <= b;
		cmd_top_addr <= t;
		@(posedge sys_clk);
		cmd_wr <= 1'b0;
	endtask : wr
	// Bounded wait for ready; a timeout shows up as a failed compare.
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge sys_clk);
		#1;
		while (rdy !== 1'b1 && n < 400) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk1(rdy, 1'b1);
	endtask : wait_rdy
	task automatic cmd2(input logic [15:0] d1, input logic [15:0] d2, input logic [3:0] b, input logic t);
		wr(d1, b, t);
		wr(d2, b, t);
		wait_rdy();
	endtask : cmd2
	// Clear status and check the byte returns to idle ready.
	task automatic clr();
		wr(16'h0050, 4'h0, 1'b0);
		@(posedge sys_clk);
		#1;
		chk8(stat, 8'h80);
	endtask : clr
	// Read strobe; the answer is registered one cycle later.
	task automatic rd(output logic [15:0] r);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1 r = rd_data;
	endtask : rd
	task automatic end_sim();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 40 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Hang guard, far above the few hundred cycles the sequence needs.
	always @(posedge sys_clk) begin
		cyc++;
		if (prog_go === 1'b1) prog_cnt++;
		if (cyc == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	// Main sequence; erase-all is only ever issued in RAM or plain mode.
	initial begin
		{rst, cmd_wr, cmd_top_addr, rd_en, ram_mode, prot_off, fail_mode, clr_erased} = 8'h80;
		cmd_data = 16'h0000;
		cmd_block = 4'h0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk8(stat, 8'h80);
		chk16(rd_data, 16'h0000);
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk);
			fail_mode <= rows[i].f;
			cmd2(rows[i].c1, rows[i].c2, rows[i].b, rows[i].t);
			chk8(stat, rows[i].st);
			chk1(eerr, rows[i].st[5]);
			chk1(perr, rows[i].st[4]);
			fail_mode <= 1'b0;
			clr();
		end
		// Lock two blocks and watch busy during the lock program.
		wr(16'h0077, 4'h5, 1'b1);
		wr(16'h00d0, 4'h5, 1'b1);
		@(posedge sys_clk);
		#1;
		chk1(rdy, 1'b0);
		wait_rdy();
		cmd2(16'h0077, 16'h00d0, 4'h6, 1'b1);
		cmd2(16'h0071, 16'h00d0, 4'h5, 1'b1);
		chk1(lock_res, 1'b0);
		cmd2(16'h0020, 16'h00d0, 4'h5, 1'b1);
		chk8(stat, 8'ha0);
		clr();
		cmd2(16'h0040, 16'h1234, 4'h5, 1'b0);
		chk8(stat, 8'h90);
		// A guarded first code under error must leave no pending command behind.
		wr(16'h0020, 4'h5, 1'b1);
		#1;
		chk8(stat, 8'h90);
		clr();
		@(posedge sys_clk);
		prot_off <= 1'b1;
		cmd2(16'h0040, 16'h1234, 4'h5, 1'b0);
		chk8(stat, 8'h80);
		cmd2(16'h0020, 16'h00d0, 4'h5, 1'b1);
		chk8(stat, 8'h80);
		@(posedge sys_clk);
		prot_off <= 1'b0;
		cmd2(16'h0071, 16'h00d0, 4'h5, 1'b1);
		chk1(lock_res, 1'b1);
		cmd2(16'h0071, 16'h00d0, 4'h6, 1'b1);
		chk1(lock_res, 1'b0);
		// Erase-all in RAM mode with blocks 1 and 6 locked; both must be skipped.
		cmd2(16'h0077, 16'h00d0, 4'h1, 1'b1);
		@(posedge sys_clk);
		ram_mode <= 1'b1;
		clr_erased <= 1'b1;
		@(posedge sys_clk);
		clr_erased <= 1'b0;
		wr(16'h00a7, 4'h0, 1'b0);
		wr(16'h00d0, 4'h0, 1'b0);
		@(posedge sys_clk);
		#1;
		chk1(status_mode, 1'b1);
		rd(v);
		chk8(v[7:0], 8'h00);
		wait_rdy();
		chk16({6'h00, erased}, 16'h01bd);
		rd(v);
		chk8(v[7:0], 8'h80);
		wr(16'h00ff, 4'h0, 1'b0);
		rd(v);
		chk16(v, 16'h3c5a);
		chk1(status_mode, 1'b0);
		// Lock status read ends the status mode that an erase opened.
		cmd2(16'h0020, 16'h00d0, 4'h0, 1'b1);
		chk1(status_mode, 1'b1);
		cmd2(16'h0071, 16'h00d0, 4'h0, 1'b1);
		chk1(status_mode, 1'b0);
		// One status read in plain mode, then array data again.
		@(posedge sys_clk);
		ram_mode <= 1'b0;
		wr(16'h0070, 4'h0, 1'b0);
		rd(v);
		chk8(v[7:0], 8'h80);
		rd(v);
		chk16(v, 16'h3c5a);
		// Three programs reach the array; the one on a locked block with protection on never does.
		chk8(8'(prog_cnt), 8'h03);
		end_sim();
	end
endmodule : flse_sequencer_test
